// File: inc/vic_pkg.sv
package vic_pkg;
   localparam int AXI_AW = 8;
   localparam int N_EXT = 4;
   localparam int LVL_W = 3;
   localparam int SRC_W = 4;
   localparam int N_EV = 3;
   // Register byte offsets
   localparam logic [AXI_AW-1:0] OFF_EDGE_MODE = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_EXT_SENS = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_PRIO0 = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_PRIO1 = 8'h0C;
   localparam logic [AXI_AW-1:0] OFF_ENABLE = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_PENDING = 8'h14;
   localparam logic [AXI_AW-1:0] OFF_VECTOR = 8'h18;
   localparam logic [AXI_AW-1:0] OFF_PEND_CLR = 8'h1C;
   localparam logic [AXI_AW-1:0] OFF_INT_STAT = 8'h20;
   localparam logic [AXI_AW-1:0] OFF_INT_MASK = 8'h24;
   // Field positions
   localparam int PRIO_STRIDE = 4;
   localparam int VEC_SRC_LSB = 0;
   localparam int VEC_LVL_LSB = 8;
   localparam int VEC_VALID_BIT = 31;
   localparam int EV_NORM = 0;
   localparam int EV_FAST = 1;
   localparam int EV_SPUR = 2;
   localparam logic [31:0] PRIO_FIELD_MASK = 32'h77777777;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   // External pin sensitivity codes
   typedef enum logic [1:0] {
      VIC_SENS_LOW = 2'h0,
      VIC_SENS_HIGH = 2'h1,
      VIC_SENS_FALL = 2'h2,
      VIC_SENS_RISE = 2'h3
   } vic_sens_t;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   function automatic logic [31:0] vic_wmerge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// File: src/vic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module vic_sync #(
   parameter int W = 1
)(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
      end
   end

   assign sync_o = s2_q;
endmodule
`default_nettype wire

// File: src/vic_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module vic_prio_enc import vic_pkg::*; #(
   parameter int N = 12
)(
   // Requests and their levels
   input wire logic [N-1:0] req_i,
   input wire logic [N*LVL_W-1:0] prio_i,
   // Winner
   output logic valid_o,
   output logic [SRC_W-1:0] idx_o,
   output logic [LVL_W-1:0] lvl_o
);
   always_comb begin
      valid_o = 1'h0;
      idx_o = '0;
      lvl_o = '0;
      // Strictly greater replaces, so ties keep the lowest index
      for (int i = 0; i < N; i++) begin
         if (req_i[i] && (!valid_o || prio_i[i*LVL_W +: LVL_W] > lvl_o)) begin
            valid_o = 1'h1;
            idx_o = SRC_W'(i);
            lvl_o = prio_i[i*LVL_W +: LVL_W];
         end
      end
   end
endmodule
`default_nettype wire

// File: src/vic_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Eight-level programmable priority encoder orders all normal-request sources.
// - Every source has its own enable; a vector names the serviced source.
// - Two outputs: one to the core fast input, one to normal input.
// - Fast request comes only from the fast-request pin, never from peripherals.
// - Normal request comes from peripheral lines and external pins zero to three.
// - Each internal source is individually level sensitive or edge triggered.
// - External sources choose rising, falling, high-level or low-level sensitivity.
// - Each parallel-I/O controller and each timer channel is a separate source.
module vic_top import vic_pkg::*; #(
   parameter int N_PAR = 2,
   parameter int N_TMR = 6
)(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Interrupt sources
   input wire logic fast_request_pin_i,
   input wire logic [N_EXT-1:0] ext_request_pin_i,
   input wire logic [N_PAR-1:0] parallel_io_ctrl_irq_i,
   input wire logic [N_TMR-1:0] timer_channel_irq_i,
   // Processor core requests, active low
   output logic core_fast_request_n_o,
   output logic core_normal_request_n_o,
   // Block interrupt
   output logic irq_o,
   // AXI4-Lite write address and data
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int N_INT = N_PAR + N_TMR;
   localparam int NSRC = N_EXT + N_INT;
   localparam int NALL = NSRC + 1;
   localparam int FAST = NSRC;

   // Source sampling
   logic [N_EXT:0] pin_s;
   logic [NALL-1:0] raw;
   logic [NALL-1:0] prev_q;
   logic [NALL-1:0] prev_d;
   logic [NALL-1:0] edge_sel;
   logic [NALL-1:0] pol;
   logic [NALL-1:0] active;
   logic [NALL-1:0] edge_hit;
   logic [NALL-1:0] pend;

   // Configuration and state registers
   logic [N_INT-1:0] edge_mode_q;
   logic [N_INT-1:0] edge_mode_d;
   logic [2*(N_EXT+1)-1:0] ext_sens_q;
   logic [2*(N_EXT+1)-1:0] ext_sens_d;
   logic [63:0] prio_q;
   logic [63:0] prio_d;
   logic [NALL-1:0] enable_q;
   logic [NALL-1:0] enable_d;
   logic [NALL-1:0] edge_pend_q;
   logic [NALL-1:0] edge_pend_d;
   logic [NALL-1:0] clr;
   logic [31:0] vector_q;
   logic [31:0] vector_d;
   logic fast_q;
   logic fast_d;
   logic norm_q;
   logic norm_d;
   logic [N_EV-1:0] stat_q;
   logic [N_EV-1:0] stat_d;
   logic [N_EV-1:0] imask_q;
   logic [N_EV-1:0] imask_d;
   logic [N_EV-1:0] ev;

   // Bus state
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic aw_go;
   logic ar_go;
   logic [31:0] wmask;
   logic [31:0] edge_mode_m;
   logic [31:0] ext_sens_m;
   logic [31:0] enable_m;
   logic [31:0] imask_m;

   // Encoder
   logic [NSRC*LVL_W-1:0] prio_vec;
   logic enc_valid;
   logic [SRC_W-1:0] enc_idx;
   logic [LVL_W-1:0] enc_lvl;

   vic_sync #(
      .W(N_EXT + 1)
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({fast_request_pin_i, ext_request_pin_i}),
      .sync_o(pin_s)
   );

   // Source map: pins 0..3, parallel I/O lines, timer channels, fast last
   assign raw = {pin_s[N_EXT], timer_channel_irq_i, parallel_io_ctrl_irq_i,
      pin_s[N_EXT-1:0]};

   genvar g;
   generate
      for (g = 0; g < NALL; g++) begin : g_src
         if (g < N_EXT || g == FAST) begin : g_ext
            localparam int E = (g == FAST) ? N_EXT : g;
            assign edge_sel[g] = ext_sens_q[2*E+1];
            assign pol[g] = ext_sens_q[2*E];
         end else begin : g_int
            assign edge_sel[g] = edge_mode_q[g-N_EXT];
            assign pol[g] = 1'h1;
         end
         assign active[g] = pol[g] ? raw[g] : ~raw[g];
         assign edge_hit[g] = active[g] & ~(pol[g] ? prev_q[g] : ~prev_q[g]);
         assign pend[g] = edge_sel[g] ? edge_pend_q[g] : active[g];
         if (g < NSRC) begin : g_pv
            assign prio_vec[g*LVL_W +: LVL_W] =
               prio_q[g*PRIO_STRIDE +: LVL_W];
         end
      end
   endgenerate

   vic_prio_enc #(
      .N(NSRC)
   ) u_enc (
      .req_i(pend[NSRC-1:0] & enable_q[NSRC-1:0]),
      .prio_i(prio_vec),
      .valid_o(enc_valid),
      .idx_o(enc_idx),
      .lvl_o(enc_lvl)
   );

   assign aw_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign ar_go = s_axi_arvalid & ~rvalid_q;
   assign wmask = vic_wmerge(RST_ZERO, s_axi_wdata, s_axi_wstrb);
   // Byte-lane merges of the narrow registers, cut to width below
   assign edge_mode_m = vic_wmerge(32'(edge_mode_q), s_axi_wdata,
      s_axi_wstrb);
   assign ext_sens_m = vic_wmerge(32'(ext_sens_q), s_axi_wdata,
      s_axi_wstrb);
   assign enable_m = vic_wmerge(32'(enable_q), s_axi_wdata, s_axi_wstrb);
   assign imask_m = vic_wmerge(32'(imask_q), s_axi_wdata, s_axi_wstrb);

   // Register writes and write response
   always_comb begin
      edge_mode_d = edge_mode_q;
      ext_sens_d = ext_sens_q;
      prio_d = prio_q;
      enable_d = enable_q;
      imask_d = imask_q;
      clr = '0;
      bvalid_d = bvalid_q & ~s_axi_bready;
      bresp_d = bresp_q;
      if (aw_go) begin
         bvalid_d = 1'h1;
         bresp_d = AXI_OKAY;
         case (s_axi_awaddr)
            OFF_EDGE_MODE: begin
               edge_mode_d = edge_mode_m[N_INT-1:0];
            end
            OFF_EXT_SENS: begin
               ext_sens_d = ext_sens_m[2*(N_EXT+1)-1:0];
            end
            OFF_PRIO0: begin
               prio_d[31:0] = vic_wmerge(prio_q[31:0], s_axi_wdata,
                  s_axi_wstrb) & PRIO_FIELD_MASK;
            end
            OFF_PRIO1: begin
               prio_d[63:32] = vic_wmerge(prio_q[63:32], s_axi_wdata,
                  s_axi_wstrb) & PRIO_FIELD_MASK;
            end
            OFF_ENABLE: begin
               enable_d = enable_m[NALL-1:0];
            end
            OFF_PEND_CLR: begin
               clr = wmask[NALL-1:0];
            end
            OFF_INT_MASK: begin
               imask_d = imask_m[N_EV-1:0];
            end
            OFF_PENDING, OFF_VECTOR, OFF_INT_STAT: begin
               bresp_d = AXI_OKAY;
            end
            default: begin
               bresp_d = AXI_SLVERR;
            end
         endcase
      end
   end

   // Register reads and their side effects
   always_comb begin
      rvalid_d = rvalid_q & ~s_axi_rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      stat_d = stat_q;
      ev = '0;
      ev[EV_NORM] = norm_d & ~norm_q;
      ev[EV_FAST] = fast_d & ~fast_q;
      if (ar_go) begin
         rvalid_d = 1'h1;
         rresp_d = AXI_OKAY;
         rdata_d = '0;
         case (s_axi_araddr)
            OFF_EDGE_MODE: rdata_d[N_INT-1:0] = edge_mode_q;
            OFF_EXT_SENS: rdata_d[2*(N_EXT+1)-1:0] = ext_sens_q;
            OFF_PRIO0: rdata_d = prio_q[31:0];
            OFF_PRIO1: rdata_d = prio_q[63:32];
            OFF_ENABLE: rdata_d[NALL-1:0] = enable_q;
            OFF_PENDING: rdata_d[NALL-1:0] = pend;
            OFF_VECTOR: begin
               rdata_d = vector_q;
               ev[EV_SPUR] = ~vector_q[VEC_VALID_BIT];
            end
            OFF_PEND_CLR: rdata_d = '0;
            OFF_INT_STAT: begin
               rdata_d[N_EV-1:0] = stat_q;
               stat_d = '0;
            end
            OFF_INT_MASK: rdata_d[N_EV-1:0] = imask_q;
            default: rresp_d = AXI_SLVERR;
         endcase
      end
      // A new event in the clearing cycle still sets its bit
      stat_d = stat_d | ev;
   end

   // Pending, vector and core requests
   always_comb begin
      prev_d = raw;
      edge_pend_d = '0;
      for (int i = 0; i < NALL; i++) begin
         // Vector read acknowledges the source it names
         if (ar_go && s_axi_araddr == OFF_VECTOR &&
               vector_q[VEC_VALID_BIT] &&
               vector_q[VEC_SRC_LSB +: SRC_W] == SRC_W'(i)) begin
            edge_pend_d[i] = edge_sel[i] & edge_hit[i];
         end else begin
            edge_pend_d[i] = edge_sel[i] &
               (edge_hit[i] | (edge_pend_q[i] & ~clr[i]));
         end
      end
      vector_d = '0;
      vector_d[VEC_VALID_BIT] = enc_valid;
      vector_d[VEC_LVL_LSB +: LVL_W] = enc_lvl;
      vector_d[VEC_SRC_LSB +: SRC_W] = enc_idx;
      fast_d = pend[FAST] & enable_q[FAST];
      norm_d = enc_valid;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prev_q <= '0;
         edge_mode_q <= '0;
         ext_sens_q <= '0;
         prio_q <= '0;
         enable_q <= '0;
         edge_pend_q <= '0;
         vector_q <= RST_ZERO;
         fast_q <= 1'h0;
         norm_q <= 1'h0;
         stat_q <= '0;
         imask_q <= '0;
         bvalid_q <= 1'h0;
         bresp_q <= AXI_OKAY;
         rvalid_q <= 1'h0;
         rresp_q <= AXI_OKAY;
         rdata_q <= RST_ZERO;
      end else begin
         prev_q <= prev_d;
         edge_mode_q <= edge_mode_d;
         ext_sens_q <= ext_sens_d;
         prio_q <= prio_d;
         enable_q <= enable_d;
         edge_pend_q <= edge_pend_d;
         vector_q <= vector_d;
         fast_q <= fast_d;
         norm_q <= norm_d;
         stat_q <= stat_d;
         imask_q <= imask_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign core_fast_request_n_o = ~fast_q;
   assign core_normal_request_n_o = ~norm_q;
   assign irq_o = |(stat_q & imask_q);
   assign s_axi_awready = aw_go;
   assign s_axi_wready = aw_go;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ar_go;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
endmodule
`default_nettype wire

// File: testbench/vic_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top_assertions import vic_pkg::*; #(
   parameter int N_PAR = 2,
   parameter int N_TMR = 6
)(
   // Clock, reset and sources
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic fast_request_pin_i,
   input wire logic [N_EXT-1:0] ext_request_pin_i,
   input wire logic [N_PAR-1:0] parallel_io_ctrl_irq_i,
   input wire logic [N_TMR-1:0] timer_channel_irq_i,
   // Requests and interrupt
   input wire logic core_fast_request_n_o,
   input wire logic core_normal_request_n_o,
   input wire logic irq_o,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [N_EXT+N_PAR+N_TMR-1:0] src, src_q;
   logic fast_q;
   logic acc;
   logic [2:0] fq_q, fq_d, nq_q, nq_d;
   assign src = {timer_channel_irq_i, parallel_io_ctrl_irq_i,
      ext_request_pin_i};
   assign acc = (s_axi_awvalid && s_axi_awready) ||
      (s_axi_arvalid && s_axi_arready);
   // Quiet cycles since a source change or a register access
   always_comb begin
      fq_d = fq_q + {2'h0, fq_q != 3'h7};
      nq_d = nq_q + {2'h0, nq_q != 3'h7};
      if (acc || fast_q != fast_request_pin_i) begin
         fq_d = 3'h0;
      end
      if (acc || src_q != src) begin
         nq_d = 3'h0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      src_q <= src;
      fast_q <= fast_request_pin_i;
      fq_q <= rst_i ? 3'h0 : fq_d;
      nq_q <= rst_i ? 3'h0 : nq_d;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_reset_idle: assert property ($fell(rst_i) |->
      core_fast_request_n_o && core_normal_request_n_o && !irq_o &&
      !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
   a_fast_isolated: assert property (fq_q == 3'h7 |->
      $stable(core_fast_request_n_o)) else $error("fast request moved");
   a_norm_stable: assert property (nq_q == 3'h7 |->
      $stable(core_normal_request_n_o)) else $error("normal request moved");
   a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
      else $error("no write response");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("no read data");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_r_once: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read answered twice");
endmodule
bind vic_top vic_top_assertions #(.N_PAR(N_PAR), .N_TMR(N_TMR)) u_chk (
   .clk_sys_i, .rst_i, .fast_request_pin_i, .ext_request_pin_i,
   .parallel_io_ctrl_irq_i, .timer_channel_irq_i, .core_fast_request_n_o,
   .core_normal_request_n_o, .irq_o, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: testbench/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Fast request from the controller, active low
   input wire logic fast_n_i,
   // Number of fast request entries seen
   output logic [7:0] fast_cnt_o
);
   logic fast_n_q;
   logic [7:0] fast_cnt_d;
   always_comb begin
      fast_cnt_d = fast_cnt_o + {7'h0, fast_n_q && !fast_n_i};
   end
   always_ff @(posedge clk_sys_i) begin
      fast_n_q <= rst_i ? 1'h1 : fast_n_i;
      fast_cnt_o <= rst_i ? 8'h00 : fast_cnt_d;
   end
endmodule
`default_nettype wire

// File: testbench/vic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb import vic_pkg::*;;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   logic fast_request_pin_i = 1'h1;
   logic [3:0] ext_request_pin_i = 4'hF;
   logic [1:0] parallel_io_ctrl_irq_i = 2'h0;
   logic [5:0] timer_channel_irq_i = 6'h00;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic core_fast_request_n_o, core_normal_request_n_o, irq_o;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] fast_cnt;
   int num_errors = 0;
   int n_checks = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   vic_top u_dut (.clk_sys_i, .rst_i, .fast_request_pin_i,
      .ext_request_pin_i, .parallel_io_ctrl_irq_i, .timer_channel_irq_i,
      .core_fast_request_n_o, .core_normal_request_n_o, .irq_o,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   vic_core_model u_core (.clk_sys_i, .rst_i,
      .fast_n_i(core_fast_request_n_o), .fast_cnt_o(fast_cnt));
   task automatic wrap_up();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Waits for awready, bvalid, arready or rvalid by index
   task automatic await(input int k);
      logic [3:0] v;
      int i;
      for (i = 0; i < 64; i++) begin
         @(posedge clk_sys_i);
         v = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
         if (v[k] === 1'h1) break;
      end
      if (i == 64) begin
         num_errors++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] r);
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      await(0);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      await(1);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] r, input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      await(2);
      s_axi_arvalid <= 1'h0;
      await(3);
      chk(s_axi_rdata & m, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      s_axi_rready <= 1'h0;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      rd(OFF_ENABLE, RST_ZERO, AXI_OKAY);
      rd(8'h40, RST_ZERO, AXI_SLVERR);
      wr(8'h40, 32'h1, AXI_SLVERR);
      wr(OFF_PRIO0, 32'h0503_0000, AXI_OKAY);
      wr(OFF_PRIO1, 32'h0000_777D, AXI_OKAY);
      rd(OFF_PRIO1, 32'h0000_7775, AXI_OKAY);
      wr(OFF_ENABLE, 32'h0000_0FFF, AXI_OKAY);
      parallel_io_ctrl_irq_i <= 2'h1;
      timer_channel_irq_i <= 6'h05;
      tick(4);
      chk({31'h0, core_normal_request_n_o}, 32'h0);
      chk({31'h0, core_fast_request_n_o}, 32'h1);
      rd(OFF_VECTOR, 32'h8000_0506, AXI_OKAY);
      wr(OFF_ENABLE, 32'h0000_0FBF, AXI_OKAY);
      tick(2);
      rd(OFF_VECTOR, 32'h8000_0508, AXI_OKAY);
      rd(OFF_PENDING, 32'h0000_0150, AXI_OKAY);
      timer_channel_irq_i <= 6'h00;
      tick(2);
      rd(OFF_VECTOR, 32'h8000_0304, AXI_OKAY);
      parallel_io_ctrl_irq_i <= 2'h0;
      tick(2);
      rd(OFF_VECTOR, RST_ZERO, AXI_OKAY, 32'h8000_0000);
      rd(OFF_INT_STAT, 32'h0000_0005, AXI_OKAY);
      rd(OFF_INT_STAT, RST_ZERO, AXI_OKAY);
      // Internal source 3 is timer line 1, pending bit 7
      wr(OFF_EDGE_MODE, 32'h0000_0008, AXI_OKAY);
      for (int k = 0; k < 2; k++) begin
         timer_channel_irq_i <= 6'h02;
         tick(1);
         timer_channel_irq_i <= 6'h00;
         tick(3);
         rd(OFF_PENDING, 32'h0000_0080, AXI_OKAY);
         if (k == 0) begin
            rd(OFF_VECTOR, 32'h8000_0007, AXI_OKAY);
         end else begin
            wr(OFF_PEND_CLR, 32'h0000_0080, AXI_OKAY);
         end
         rd(OFF_PENDING, RST_ZERO, AXI_OKAY);
      end
      // Pin 0 under each sensitivity: inactive, active, back again
      for (int c = 0; c < 4; c++) begin
         ext_request_pin_i <= {3'h7, ~c[0]};
         wr(OFF_EXT_SENS, 32'(c), AXI_OKAY);
         tick(4);
         wr(OFF_PEND_CLR, 32'h1, AXI_OKAY);
         ext_request_pin_i <= {3'h7, c[0]};
         tick(5);
         rd(OFF_PENDING, 32'h1, AXI_OKAY);
         chk({31'h0, core_normal_request_n_o}, 32'h0);
         ext_request_pin_i <= {3'h7, ~c[0]};
         tick(5);
         rd(OFF_PENDING, {31'h0, c[1]}, AXI_OKAY);
         wr(OFF_PEND_CLR, 32'h1, AXI_OKAY);
      end
      timer_channel_irq_i <= 6'h3F;
      parallel_io_ctrl_irq_i <= 2'h3;
      tick(3);
      rd(OFF_INT_STAT, 32'h1, AXI_OKAY);
      chk({31'h0, core_fast_request_n_o}, 32'h1);
      wr(OFF_INT_MASK, 32'h2, AXI_OKAY);
      wr(OFF_ENABLE, 32'h0000_1FFF, AXI_OKAY);
      fast_request_pin_i <= 1'h0;
      tick(5);
      chk({31'h0, core_fast_request_n_o}, 32'h0);
      chk({31'h0, irq_o}, 32'h1);
      rd(OFF_INT_STAT, 32'h2, AXI_OKAY);
      tick(2);
      chk({31'h0, irq_o}, 32'h0);
      wr(OFF_INT_MASK, RST_ZERO, AXI_OKAY);
      fast_request_pin_i <= 1'h1;
      tick(5);
      fast_request_pin_i <= 1'h0;
      tick(5);
      chk({31'h0, irq_o}, 32'h0);
      chk({24'h0, fast_cnt}, 32'h2);
      wrap_up();
   end
endmodule
`default_nettype wire
